// ===== logic/dss_pkg.sv
/*
 Shared constants and types of the drive state and status word block.
 Assumes a single 125 MHz clock and a classic Wishbone register bus.
*/
package dss_pkg;
   localparam int CLK_HZ = 125000000;
   localparam int ADDR_W = 4;
   localparam int TO_MS_DEF = 1000;
   localparam int TO_CYC_DEF = TO_MS_DEF * (CLK_HZ / 1000);
   localparam int TO_W = 32;

   // Byte offsets
   localparam logic [ADDR_W-1:0] OFF_STATE_WORD = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_COMMAND = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'hC;

   // Status word bit positions
   localparam int SB_RDY = 0;
   localparam int SB_SON = 1;
   localparam int SB_OPEN = 2;
   localparam int SB_FLT = 3;
   localparam int SB_VOLT = 4;
   localparam int SB_QSN = 5;
   localparam int SB_SOD = 6;
   localparam int SB_WARN = 7;
   localparam int SB_REM = 9;
   localparam int SB_TGT = 10;
   localparam int SB_LIM = 11;
   localparam int SB_STOPKEY = 14;
   localparam int SB_DIR = 15;

   // Command register bits
   localparam int CB_SWON = 0;
   localparam int CB_ENV = 1;
   localparam int CB_QSN = 2;
   localparam int CB_ENOP = 3;
   localparam int CB_FRST = 7;
   localparam int CB_CONTACTOR = 16;

   // Interrupt bits
   localparam int IRQ_N = 3;
   localparam int IB_STATE = 0;
   localparam int IB_CONTACTOR_ERR = 1;
   localparam int IB_FAULT = 2;

   typedef enum logic [2:0] {
      ST_NOT_READY = 3'b000,
      ST_SW_ON_DIS = 3'b001,
      ST_READY = 3'b010,
      ST_SWITCHED_ON = 3'b011,
      ST_OP_ENABLED = 3'b100,
      ST_QUICK_STOP = 3'b101,
      ST_FAULT_REACT = 3'b110,
      ST_FAULT = 3'b111
   } dss_state_t;

   typedef struct packed {
      logic power_present;
      logic warning;
      logic remote;
      logic target_reached;
      logic limit_active;
      logic stop_key;
      logic direction;
      logic fault_cause;
      logic init_done;
      logic react_done;
   } dss_drive_t;
endpackage

// ===== logic/dss_sync.sv
/*
 Two flip-flop synchroniser for a group of level inputs.
 Assumes the inputs are asynchronous to clk_i.
*/
module dss_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

// ===== logic/dss_top.sv
/*
 Drive operating state machine, status word encoder, mains voltage timeout
 and contactor control, with a classic Wishbone slave and interrupt.
 Assumes the drive condition inputs are asynchronous pins.
*/
// Overview of operation
// RULE_01: Low status byte: ready, on, enabled, fault, voltage, quick stop low, disabled, warning.
// RULE_02: High byte: remote, target, limit, stop key, direction; bits 8, 12, 13 zero.
// RULE_03: Status masked by 006F gives 0040, 0021, 0023, 0027, 0007 per state.
// RULE_04: Not ready clears 6..0 bits (code keeps bit 4 following the power voltage); reaction sets fault and 2..0; fault sets fault.
// RULE_05: Fault entered from quick stop reads 0028 masked, quick stop bit high.
// RULE_06: Enable operation from ready to switch on goes straight to operation enabled.
// RULE_07: Ready to switch on reports 21 hex without, 31 hex with power voltage.
// RULE_08: Controller confirms switched on before enable operation with separate control stage.
// RULE_09: Voltage absent after timeout in switched on raises contactor error and fault.
// RULE_10: With contactor control, contactor stays open in states before switch on.
// RULE_11: With contactor control, switch on in ready closes the contactor.
// RULE_12: Controller moves the motor by sending a nonzero reference when enabled.
// RULE_13: Controller encodes shutdown 0006, switch on 0007, enable operation 000F.
// RULE_14: Fault reset acts on rising edge only, to switch on disabled once cleared.
// RULE_15: Status word updates in the same cycle as the state register.
// RULE_16: Timeout counter restarts on entry to switched on, stops on voltage or exit.
module dss_top #(
   parameter int TO_CYC = dss_pkg::TO_CYC_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [dss_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire dss_pkg::dss_drive_t drive_i,
   output logic [15:0] drive_state_word_o,
   output logic contactor_close_o,
   output logic supply_absent_display_o,
   output logic irq_o
);
   import dss_pkg::*;

   dss_drive_t drv;
   dss_state_t state;
   dss_state_t next_state;
   logic [15:0] drive_state_word;
   logic [15:0] next_word;
   logic [CB_CONTACTOR:0] command;
   logic frst_d;
   logic from_qs;
   logic next_from_qs;
   logic [TO_W-1:0] to_cnt;
   logic to_err;
   logic [IRQ_N-1:0] irq_status;
   logic [IRQ_N-1:0] irq_mask;
   logic [IRQ_N-1:0] irq_event;
   logic [IRQ_N-1:0] next_irq_status;
   logic wb_req;
   logic wb_wr;
   logic wb_rd_status;
   logic frst_rise;
   logic cmd_shutdown;
   logic cmd_switch_on;
   logic cmd_enable;
   logic cmd_disable_v;
   logic cmd_quick;
   logic contactor_mode;

   dss_sync #(
      .W($bits(dss_drive_t))
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(drive_i),
      .q_o(drv)
   );

   // Command decode
   assign cmd_disable_v = !command[CB_ENV];
   assign cmd_quick = command[CB_ENV] && !command[CB_QSN];
   assign cmd_shutdown = command[CB_ENV] && command[CB_QSN] && !command[CB_SWON];
   assign cmd_switch_on = command[CB_ENV] && command[CB_QSN] && command[CB_SWON] && !command[CB_ENOP];
   assign cmd_enable = command[CB_ENV] && command[CB_QSN] && command[CB_SWON] && command[CB_ENOP];
   assign contactor_mode = command[CB_CONTACTOR];
   assign frst_rise = command[CB_FRST] && !frst_d; // RULE_14

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frst_d <= 1'b0;
      end else begin
         frst_d <= command[CB_FRST];
      end
   end

   // Next state
   always_comb begin
      next_state = state;
      next_from_qs = from_qs;
      unique case (state)
         ST_NOT_READY: begin
            if (drv.init_done) begin
               next_state = ST_SW_ON_DIS;
            end
         end
         ST_SW_ON_DIS: begin
            if (cmd_shutdown) begin
               next_state = ST_READY;
            end
         end
         ST_READY: begin
            if (cmd_disable_v || cmd_quick) begin
               next_state = ST_SW_ON_DIS;
            end else if (cmd_enable) begin
               next_state = ST_OP_ENABLED; // RULE_06
            end else if (cmd_switch_on) begin
               next_state = ST_SWITCHED_ON;
            end
         end
         ST_SWITCHED_ON: begin
            if (to_err) begin
               next_state = ST_FAULT_REACT; // RULE_09
               next_from_qs = 1'b0;
            end else if (cmd_disable_v || cmd_quick) begin
               next_state = ST_SW_ON_DIS;
            end else if (cmd_shutdown) begin
               next_state = ST_READY;
            end else if (cmd_enable) begin
               next_state = ST_OP_ENABLED;
            end
         end
         ST_OP_ENABLED: begin
            if (drv.fault_cause) begin
               next_state = ST_FAULT_REACT;
               next_from_qs = 1'b0;
            end else if (cmd_disable_v) begin
               next_state = ST_SW_ON_DIS;
            end else if (cmd_quick) begin
               next_state = ST_QUICK_STOP;
            end else if (cmd_shutdown) begin
               next_state = ST_READY;
            end else if (cmd_switch_on) begin
               next_state = ST_SWITCHED_ON;
            end
         end
         ST_QUICK_STOP: begin
            if (drv.fault_cause) begin
               next_state = ST_FAULT_REACT;
               next_from_qs = 1'b1; // RULE_05
            end else if (cmd_disable_v || drv.react_done) begin
               next_state = ST_SW_ON_DIS;
            end
         end
         ST_FAULT_REACT: begin
            if (drv.react_done) begin
               next_state = ST_FAULT;
            end
         end
         ST_FAULT: begin
            if (frst_rise && !drv.fault_cause) begin
               next_state = ST_SW_ON_DIS; // RULE_14
               next_from_qs = 1'b0;
            end
         end
      endcase
      if (drv.fault_cause && state != ST_FAULT && state != ST_FAULT_REACT && state != ST_NOT_READY) begin
         next_state = ST_FAULT_REACT;
         next_from_qs = (state == ST_QUICK_STOP);
      end
   end

   // Status word from the next state
   always_comb begin
      next_word = '0;
      next_word[SB_VOLT] = drv.power_present; // RULE_07
      next_word[SB_WARN] = drv.warning;
      next_word[SB_REM] = drv.remote; // RULE_02
      next_word[SB_TGT] = drv.target_reached;
      next_word[SB_LIM] = drv.limit_active;
      next_word[SB_STOPKEY] = drv.stop_key;
      next_word[SB_DIR] = drv.direction;
      unique case (next_state) // RULE_01 RULE_03 RULE_04
         ST_NOT_READY: begin
         end
         ST_SW_ON_DIS: begin
            next_word[SB_SOD] = 1'b1;
         end
         ST_READY: begin
            next_word[SB_QSN] = 1'b1;
            next_word[SB_RDY] = 1'b1;
         end
         ST_SWITCHED_ON, ST_OP_ENABLED: begin
            next_word[SB_QSN] = 1'b1;
            next_word[SB_RDY] = 1'b1;
            next_word[SB_SON] = 1'b1;
            next_word[SB_OPEN] = (next_state == ST_OP_ENABLED);
         end
         ST_QUICK_STOP: begin
            next_word[SB_RDY] = 1'b1;
            next_word[SB_SON] = 1'b1;
            next_word[SB_OPEN] = 1'b1;
         end
         ST_FAULT_REACT: begin
            next_word[SB_FLT] = 1'b1;
            next_word[SB_RDY] = 1'b1;
            next_word[SB_SON] = 1'b1;
            next_word[SB_OPEN] = 1'b1;
            next_word[SB_QSN] = next_from_qs;
         end
         ST_FAULT: begin
            next_word[SB_FLT] = 1'b1;
            next_word[SB_QSN] = next_from_qs; // RULE_05
         end
      endcase
   end

   // State and status word registered together
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_NOT_READY;
         from_qs <= 1'b0;
         drive_state_word <= '0;
      end else begin
         state <= next_state;
         from_qs <= next_from_qs;
         drive_state_word <= next_word; // RULE_15
      end
   end

   // Mains voltage timeout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         to_cnt <= '0;
         to_err <= 1'b0;
      end else if (state != ST_SWITCHED_ON || drv.power_present) begin
         to_cnt <= '0; // RULE_16
         to_err <= 1'b0;
      end else if (to_cnt >= TO_W'(TO_CYC - 1)) begin
         to_err <= 1'b1; // RULE_09
      end else begin
         to_cnt <= to_cnt + 1'b1; // RULE_16
      end
   end

   // Contactor output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         contactor_close_o <= 1'b0;
      end else begin
         if (!contactor_mode) begin
            contactor_close_o <= 1'b0;
         end else if (next_state == ST_NOT_READY || next_state == ST_SW_ON_DIS || next_state == ST_READY) begin
            contactor_close_o <= 1'b0; // RULE_10
         end else if (state == ST_READY && (cmd_switch_on || cmd_enable)) begin
            contactor_close_o <= 1'b1; // RULE_11
         end
      end
   end

   // Supply absent display, in step with the status word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         supply_absent_display_o <= 1'b0;
      end else begin
         supply_absent_display_o <= (next_state == ST_READY) && !drv.power_present; // RULE_07
      end
   end

   // Wishbone slave
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i;
   assign wb_rd_status = wb_req && !wb_we_i && wb_adr_i == OFF_IRQ_STATUS;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= '0;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               OFF_STATE_WORD: wb_dat_o <= {16'h0000, drive_state_word};
               OFF_COMMAND: wb_dat_o <= 32'(command);
               OFF_IRQ_STATUS: wb_dat_o <= 32'(irq_status);
               OFF_IRQ_MASK: wb_dat_o <= 32'(irq_mask);
               default: wb_dat_o <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         command <= '0;
         irq_mask <= '0;
      end else if (wb_wr) begin
         if (wb_adr_i == OFF_COMMAND) begin
            if (wb_sel_i[0]) begin
               command[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               command[15:8] <= wb_dat_i[15:8];
            end
            if (wb_sel_i[2]) begin
               command[CB_CONTACTOR] <= wb_dat_i[CB_CONTACTOR];
            end
         end
         if (wb_adr_i == OFF_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask <= wb_dat_i[IRQ_N-1:0];
         end
      end
   end

   // Interrupt events, set wins over read clear
   assign irq_event[IB_STATE] = (next_state != state);
   assign irq_event[IB_CONTACTOR_ERR] = (state == ST_SWITCHED_ON) && (next_state == ST_FAULT_REACT) && to_err;
   assign irq_event[IB_FAULT] = (next_state == ST_FAULT_REACT) && (state != ST_FAULT_REACT);

   assign next_irq_status = (wb_rd_status ? '0 : irq_status) | irq_event;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= '0;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   // Level interrupt from the updated status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(next_irq_status & irq_mask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_state_word_o <= '0;
      end else begin
         drive_state_word_o <= next_word;
      end
   end
endmodule

// ===== testbench/dss_checker.sv
/*
 Concurrent checks on the ports of dss_top, bound below.
 Assumes one clock and a synchronous active high reset.
*/
module dss_checker import dss_pkg::*; #(
   parameter int TO_CYC = 20
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire dss_pkg::dss_drive_t drive_i,
   input wire logic [15:0] drive_state_word_o,
   input wire logic contactor_close_o,
   input wire logic supply_absent_display_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] up_cnt;
   logic [31:0] wait_cnt;
   logic [6:0] st;
   logic [15:0] w;
   assign w = drive_state_word_o;
   assign st = w[6:0] & 7'h6F;
   // Cycles since reset release
   always_ff @(posedge clk_i)
      if (rst_i) up_cnt <= 3'h0;
      else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
   // Cycles switched on without power stage voltage
   always_ff @(posedge clk_i)
      if (rst_i || st != 7'h23 || w[SB_VOLT]) wait_cnt <= 32'h0;
      else wait_cnt <= wait_cnt + 32'h1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_pulse: assert property (s_req |=> s_pulse)
      else $error("ack is not a single pulse");
   a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero without ack");
   a_state_legal: assert property ({w[6], w[3:0]} inside {5'h00, 5'h10, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h08})
      else $error("illegal state bit pattern");
   a_reserved_zero: assert property (w[8] == 1'b0 && w[13:12] == 2'h0)
      else $error("reserved status bits set");
   a_volt_bit: assert property (up_cnt == 3'h7 |-> w[SB_VOLT] == $past(drive_i.power_present, 3))
      else $error("voltage bit does not follow supply");
   a_flags_follow: assert property (up_cnt == 3'h7 |-> {w[15:14], w[11:9], w[7]} == $past({drive_i.direction,
      drive_i.stop_key, drive_i.limit_active, drive_i.target_reached, drive_i.remote, drive_i.warning}, 3))
      else $error("status flags do not follow drive");
   a_absent_disp: assert property (supply_absent_display_o == (st == 7'h21 && !w[SB_VOLT]))
      else $error("supply absent display wrong");
   a_close_ready: assert property ($rose(contactor_close_o) |-> $past(st) == 7'h21)
      else $error("contactor closed outside ready");
   a_open_disabled: assert property (w[SB_SOD] && $past(w[SB_SOD]) |-> !contactor_close_o)
      else $error("contactor closed while disabled");
   a_timeout_bound: assert property (wait_cnt <= TO_CYC + 4)
      else $error("mains timeout did not end switched on");
   a_fault_exit: assert property ($past(w[3] && w[2:0] == 3'h0) && !w[3] |-> w[SB_SOD])
      else $error("fault left to wrong state");
endmodule
bind dss_top dss_checker #(.TO_CYC(TO_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drive_i(drive_i),
   .drive_state_word_o(drive_state_word_o), .contactor_close_o(contactor_close_o),
   .supply_absent_display_o(supply_absent_display_o));

// ===== testbench/dss_plant.sv
/*
 Drive side model: power stage supply, fault cause, reaction end, flags.
 Assumes it sees the status word and contactor output of the block.
*/
module dss_plant import dss_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic contactor_close_i,
   input wire logic mains_on_i,
   input wire logic fault_cause_i,
   input wire logic [5:0] flags_i,
   input wire logic [15:0] word_i,
   output dss_pkg::dss_drive_t drive_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] react_cnt = 5'h0;
   initial drive_o = '0;
   // Reaction lasts 16 cycles
   always @(posedge clk_i)
      if (rst_i || !(word_i[3] && word_i[0])) react_cnt <= 5'h0;
      else if (!react_cnt[4]) react_cnt <= react_cnt + 5'h1;
   always @(posedge clk_i) begin
      drive_o.power_present <= !rst_i && (mains_on_i || contactor_close_i);
      {drive_o.warning, drive_o.remote, drive_o.target_reached} <= flags_i[5:3];
      {drive_o.limit_active, drive_o.stop_key, drive_o.direction} <= flags_i[2:0];
      drive_o.fault_cause <= fault_cause_i;
      drive_o.init_done <= !rst_i;
      drive_o.react_done <= react_cnt[4];
   end
endmodule

// ===== testbench/dss_top_tb.sv
/*
 Self-checking bench for dss_top: Wishbone master, plant, read scoreboard.
 Assumes the checker is bound to dss_top by its own file.
*/
module dss_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dss_pkg::*;
   localparam int TO = 20;
   localparam logic [3:0] CMD = OFF_COMMAND;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, mains = 0, cause = 0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, contactor, absent, irq_o;
   logic [5:0] flags = 6'h0;
   logic [15:0] word, qe[$], qm[$];
   dss_drive_t drive;
   int n_mismatch = 0, compares = 0, cyc = 0, seed = 13600;
   dss_top #(.TO_CYC(TO)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .drive_i(drive), .drive_state_word_o(word), .contactor_close_o(contactor),
      .supply_absent_display_o(absent), .irq_o(irq_o));
   dss_plant plant (.clk_i(clk_i), .rst_i(rst_i), .contactor_close_i(contactor), .mains_on_i(mains),
      .fault_cause_i(cause), .flags_i(flags), .word_i(word), .drive_o(drive));
   initial forever #4 clk_i = ~clk_i;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hF};
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
   endtask
   task automatic settle();
      repeat (8) @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
      settle();
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      qe.push_back(e);
      qm.push_back(m);
      bus(a, 1'b0, 32'h0);
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Scoreboard of read results
   always @(posedge clk_i)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o[15:0] & qm.pop_front(), qe.pop_front());
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      rd(OFF_STATE_WORD, 16'h0040, 16'h006F);
      rd(4'h2, 16'h0000, 16'hFFFF);
      wr(CMD, 32'h6);
      rd(OFF_STATE_WORD, 16'h0021, 16'h00FF);
      mains <= 1'b1;
      settle();
      rd(OFF_STATE_WORD, 16'h0031, 16'h00FF);
      wr(CMD, 32'h7);
      rd(OFF_STATE_WORD, 16'h0023, 16'h006F);
      wr(CMD, 32'hF);
      rd(OFF_STATE_WORD, 16'h0027, 16'h006F);
      $display("start with separate control stage done");
      wr(CMD, 32'hB);
      rd(OFF_STATE_WORD, 16'h0007, 16'h006F);
      cause <= 1'b1;
      repeat (6) @(posedge clk_i);
      rd(OFF_STATE_WORD, 16'h000F, 16'h000F);
      repeat (30) @(posedge clk_i);
      rd(OFF_STATE_WORD, 16'h0028, 16'h006F);
      wr(CMD, 32'h0);
      wr(CMD, 32'h80);
      cause <= 1'b0;
      settle();
      rd(OFF_STATE_WORD, 16'h0028, 16'h006F);
      wr(CMD, 32'h0);
      wr(CMD, 32'h80);
      rd(OFF_STATE_WORD, 16'h0040, 16'h006F);
      $display("quick stop and fault reset done");
      for (int i = 0; i < 4; i++) begin
         flags <= 6'($random(seed));
         settle();
         rd(OFF_STATE_WORD, {flags[0], flags[1], 2'b00, flags[2], flags[3], flags[4], 1'b0, flags[5], 7'h0}, 16'hFF80);
      end
      flags <= 6'h0;
      mains <= 1'b0;
      $display("status flags done");
      wr(CMD, 32'h10006);
      rd(OFF_STATE_WORD, 16'h0021, 16'h007F);
      wr(CMD, 32'h10007);
      rd(OFF_STATE_WORD, 16'h0033, 16'h007F);
      wr(CMD, 32'h0);
      wr(CMD, 32'h10006);
      wr(CMD, 32'h1000F);
      rd(OFF_STATE_WORD, 16'h0037, 16'h007F);
      wr(CMD, 32'h0);
      $display("contactor and direct enable done");
      rd(OFF_IRQ_STATUS, 16'h0005, 16'h0007);
      wr(OFF_IRQ_MASK, 32'h2);
      wr(CMD, 32'h6);
      wr(CMD, 32'h7);
      check({15'h0, irq_o}, 16'h0000);
      repeat (TO + 40) @(posedge clk_i);
      rd(OFF_STATE_WORD, 16'h0008, 16'h006F);
      check({15'h0, irq_o}, 16'h0001);
      rd(OFF_IRQ_STATUS, 16'h0002, 16'h0002);
      repeat (2) @(posedge clk_i);
      check({15'h0, irq_o}, 16'h0000);
      rd(OFF_IRQ_STATUS, 16'h0000, 16'h0002);
      $display("mains timeout and interrupt done");
      stop_test();
   end
endmodule
